// ### design/msr_top.sv
// vendor status byte, pad readback and busy gate of the power manager
// Operation
// R1: discharge fault on turn-on sets sticky alerting bit7
// R2: fault line one low sets sticky bit6
// R3: fault line zero low sets sticky bit5
// R4: line flags clear on toggle, cycle, clear
// R5: tracking may flag the causing channel too
// R6: bits 4,3 live servo and converter state
// R7: servo ending at limit sets sticky bit2
// R8: bit1 global live auxiliary fault release
// R9: watchdog sets sticky alerting global bit0
// R10: pad readback read-only, raw pad levels
// R11: bit15 low while we pull power-good
// R12: bit14 low while we pull alert
// R13: bits13:12 own fault drive, 11:10 zero
// R14: bits9:8 encode address select one
// R15: bits7:6 encode address select zero
// R16: control pad levels at bits 5,4,1,0
// R17: bits3:2 sampled fault pad levels
// R18: common status readable while busy
// R19: busy refuses other commands, sets busy flags
// R20: busy refusal never pulls alert
// R21: sticky flags clear on clear; channel flags also clear on turn-on
// R22: alerting flag set pulls alert low
// R23: common bit6 zero while busy
// R24: sticky flags zero after reset
module msr_top
  import msr_pkg::*;
#(
  parameter int N = MSR_CHANNELS
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  // command port from the serial bus engine
  input  wire logic         i_cmd_valid,
  input  wire logic [7:0]   i_cmd_code,
  input  wire logic [1:0]   i_cmd_page,
  input  wire logic         i_busy,
  output logic              o_cmd_nack,
  output logic              o_busy_flag_set,
  output logic              o_rd_valid,
  output logic      [15:0]  o_rd_data,
  // channel events from sequencing and servo logic
  input  wire logic         i_clear_faults,
  input  wire logic [N-1:0] i_user_on,
  input  wire logic [N-1:0] i_on_attempt,
  input  wire logic [N-1:0] i_discharge_fault,
  input  wire logic [N-1:0] i_shut_fault_one,
  input  wire logic [N-1:0] i_shut_fault_zero,
  input  wire logic [N-1:0] i_track_en,
  input  wire logic [N-1:0] i_cause_fault_one,
  input  wire logic [N-1:0] i_cause_fault_zero,
  input  wire logic [N-1:0] i_servo_reached,
  input  wire logic [N-1:0] i_dac_connected,
  input  wire logic [N-1:0] i_servo_done,
  input  wire logic [N-1:0] i_dac_at_limit,
  input  wire logic         i_aux_released,
  input  wire logic         i_watchdog_fault,
  // own pad drives from other logic on this clock
  input  wire logic         i_pwrgd_drive_low,
  input  wire logic         i_fault_zero_drive_low,
  input  wire logic         i_fault_one_drive_low,
  // raw pad levels
  input  wire logic [3:0]   i_pad_channel_control,
  input  wire logic         i_pad_shared_fault_line_zero,
  input  wire logic         i_pad_shared_fault_line_one,
  input  wire logic         i_pad_address_select_zero_hi,
  input  wire logic         i_pad_address_select_zero_float,
  input  wire logic         i_pad_address_select_one_hi,
  input  wire logic         i_pad_address_select_one_float,
  input  wire logic         i_pad_write_protect,
  input  wire logic         i_pad_share_clk_low,
  // alert pad, open drain
  input  wire logic         i_alertb_i,
  output logic              o_alertb_o,
  output logic              o_alertb_oe,
  output logic      [N-1:0] o_chan_off_event
);
  msr_state_s st_r;
  msr_state_s st_nxt;

  logic [MSR_SY_W-1:0] pad_sy;
  logic [MSR_SY_W-1:0] pad_raw;
  logic [N-1:0]        ctl_toggle;
  logic                line_zero_low;
  logic                line_one_low;
  logic                alert_event;
  logic [15:0]         status_word;
  logic [15:0]         pad_word;
  logic [15:0]         common_word;
  logic                refuse;
  logic [1:0]          sel;

  msr_sticky_if #(.W(MSR_STICKY_W)) bank_if ();

  // address-select pad level to readback code
  function automatic logic [1:0] asel_code(input logic hi, input logic flt);
    logic [1:0] c;
    c = MSR_ASEL_LOW;
    if (flt) begin
      c = MSR_ASEL_FLOAT;
    end else if (hi) begin
      c = MSR_ASEL_HIGH;
    end
    return c;
  endfunction

  // pad levels are sampled raw, ahead of any deglitch filter
  assign pad_raw = {i_pad_share_clk_low, i_pad_write_protect,
                    i_pad_address_select_one_hi, i_pad_address_select_one_float,
                    i_pad_address_select_zero_hi, i_pad_address_select_zero_float,
                    i_pad_shared_fault_line_zero, i_pad_shared_fault_line_one,
                    i_pad_channel_control};

  msr_sync #(.W(MSR_SY_W)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   (pad_raw),
    .o_sync    (pad_sy)
  );

  msr_sticky #(.W(MSR_STICKY_W)) u_sticky (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .bank      (bank_if.owner)
  );

  // fault lines are active low on the wire
  assign line_zero_low = !pad_sy[MSR_SY_FAULT0];
  assign line_one_low  = !pad_sy[MSR_SY_FAULT1];

  // control n steers channel n; no toggle seen before the first sample
  assign ctl_toggle = st_r.ctl_prev_ok ?
                      (pad_sy[MSR_SY_CTRL_LSB +: N] ^ st_r.ctl_prev) : '0;

  // per-channel set and clear terms of the sticky bank
  always_comb begin
    bank_if.set = '0;
    bank_if.clr = '0;
    for (int c = 0; c < N; c++) begin
      bank_if.set[c*MSR_K_PER_CH + MSR_K_DISCHARGE] =
        i_discharge_fault[c] & i_on_attempt[c]; // R1
      bank_if.set[c*MSR_K_PER_CH + MSR_K_FAULT_ONE] =
        (i_on_attempt[c] & line_one_low) | i_shut_fault_one[c] // R2
        | (i_track_en[c] & i_cause_fault_one[c]); // R5
      bank_if.set[c*MSR_K_PER_CH + MSR_K_FAULT_ZERO] =
        (i_on_attempt[c] & line_zero_low) | i_shut_fault_zero[c] // R3
        | (i_track_en[c] & i_cause_fault_zero[c]); // R5
      bank_if.set[c*MSR_K_PER_CH + MSR_K_DAC_SAT] =
        i_servo_done[c] & i_dac_at_limit[c]; // R7
      bank_if.clr[c*MSR_K_PER_CH + MSR_K_DISCHARGE] =
        i_clear_faults | i_user_on[c]; // R21
      bank_if.clr[c*MSR_K_PER_CH + MSR_K_DAC_SAT] =
        i_clear_faults | i_user_on[c]; // R21
      bank_if.clr[c*MSR_K_PER_CH + MSR_K_FAULT_ONE] =
        i_clear_faults | i_user_on[c] | ctl_toggle[c]; // R4
      bank_if.clr[c*MSR_K_PER_CH + MSR_K_FAULT_ZERO] =
        i_clear_faults | i_user_on[c] | ctl_toggle[c]; // R4
    end
    bank_if.set[MSR_STICKY_WDG] = i_watchdog_fault; // R9
    bank_if.clr[MSR_STICKY_WDG] = i_clear_faults; // R21
  end

  // events that may be configured elsewhere to stop a channel; watchdog never
  always_comb begin
    for (int c = 0; c < N; c++) begin
      o_chan_off_event[c] = bank_if.set[c*MSR_K_PER_CH + MSR_K_DISCHARGE]
                          | bank_if.set[c*MSR_K_PER_CH + MSR_K_FAULT_ONE]
                          | bank_if.set[c*MSR_K_PER_CH + MSR_K_FAULT_ZERO];
    end
  end

  // alerting flags: discharge, both fault lines, watchdog
  always_comb begin
    alert_event = bank_if.set[MSR_STICKY_WDG]; // R22
    for (int c = 0; c < N; c++) begin
      alert_event = alert_event
                  | bank_if.set[c*MSR_K_PER_CH + MSR_K_DISCHARGE]
                  | bank_if.set[c*MSR_K_PER_CH + MSR_K_FAULT_ONE]
                  | bank_if.set[c*MSR_K_PER_CH + MSR_K_FAULT_ZERO];
    end
  end

  // status byte of the paged channel, global bits shared
  assign sel = i_cmd_page;
  always_comb begin
    status_word = 16'h0000;
    status_word[MSR_ST_DISCHARGE]  = bank_if.q[sel*MSR_K_PER_CH + MSR_K_DISCHARGE];
    status_word[MSR_ST_FAULT_ONE]  = bank_if.q[sel*MSR_K_PER_CH + MSR_K_FAULT_ONE];
    status_word[MSR_ST_FAULT_ZERO] = bank_if.q[sel*MSR_K_PER_CH + MSR_K_FAULT_ZERO];
    status_word[MSR_ST_SERVO_HIT]  = i_servo_reached[sel]; // R6
    status_word[MSR_ST_DAC_ON]     = i_dac_connected[sel]; // R6
    status_word[MSR_ST_DAC_SAT]    = bank_if.q[sel*MSR_K_PER_CH + MSR_K_DAC_SAT];
    status_word[MSR_ST_AUX_OFF]    = i_aux_released; // R8
    status_word[MSR_ST_WATCHDOG]   = bank_if.q[MSR_STICKY_WDG];
  end

  // pad snapshot; own drives are shown, not the wire level
  always_comb begin
    pad_word = 16'h0000;
    pad_word[MSR_PD_PWRGD_DRV]    = !i_pwrgd_drive_low; // R11
    pad_word[MSR_PD_ALERT_DRV]    = !st_r.alert; // R12
    pad_word[MSR_PD_FAULT_DRV_HI] = !i_fault_zero_drive_low; // R13
    pad_word[MSR_PD_FAULT_DRV_LO] = !i_fault_one_drive_low; // R13
    pad_word[MSR_PD_RSVD_HI -: 2] = MSR_PD_RSVD_VAL; // R13
    pad_word[MSR_PD_ADDRESS_SELECT_ONE_LSB +: 2] = asel_code(pad_sy[MSR_SY_ADDRESS_SELECT_ONE_HI],
                                                pad_sy[MSR_SY_ADDRESS_SELECT_ONE_FLT]); // R14
    pad_word[MSR_PD_ADDRESS_SELECT_ZERO_LSB +: 2] = asel_code(pad_sy[MSR_SY_ADDRESS_SELECT_ZERO_HI],
                                                pad_sy[MSR_SY_ADDRESS_SELECT_ZERO_FLT]); // R15
    pad_word[MSR_PD_CTRL1] = pad_sy[MSR_SY_CTRL_LSB + 1]; // R16
    pad_word[MSR_PD_CTRL0] = pad_sy[MSR_SY_CTRL_LSB]; // R16
    pad_word[MSR_PD_CTRL2] = pad_sy[MSR_SY_CTRL_LSB + 2]; // R16
    pad_word[MSR_PD_CTRL3] = pad_sy[MSR_SY_CTRL_LSB + 3]; // R16
    pad_word[MSR_PD_FAULT_HI] = pad_sy[MSR_SY_FAULT0]; // R17
    pad_word[MSR_PD_FAULT_LO] = pad_sy[MSR_SY_FAULT1]; // R17
  end

  // common status: alert, availability, reserved ones, share clock, protect
  always_comb begin
    common_word = 16'h0000;
    common_word[MSR_CM_ALERT] = !st_r.alert;
    common_word[MSR_CM_AVAIL] = !i_busy; // R23
    common_word[5:2] = MSR_CM_RSVD_VAL;
    common_word[1] = pad_sy[MSR_SY_SHARE_LOW];
    common_word[0] = pad_sy[MSR_SY_WP];
  end

  // only the common status gets past a busy device
  assign refuse = i_cmd_valid & i_busy & (i_cmd_code != MSR_CMD_COMMON_STAT); // R19
  assign o_cmd_nack = refuse; // R19
  assign o_busy_flag_set = refuse; // R19

  // next state; a refusal never reaches the alert latch
  always_comb begin
    st_nxt = st_r;
    st_nxt.ctl_prev = pad_sy[MSR_SY_CTRL_LSB +: N];
    st_nxt.ctl_prev_ok = 1'b1;
    st_nxt.alert = (st_r.alert & !i_clear_faults) | alert_event; // R20 R22
    st_nxt.rd_valid = 1'b0;
    if (i_cmd_valid && !refuse) begin
      unique case (i_cmd_code)
        MSR_CMD_VENDOR_STAT: begin
          st_nxt.rd_valid = 1'b1;
          st_nxt.rd_data = status_word;
        end
        MSR_CMD_PAD_READBACK: begin
          st_nxt.rd_valid = 1'b1; // R10
          st_nxt.rd_data = pad_word;
        end
        MSR_CMD_COMMON_STAT: begin
          st_nxt.rd_valid = 1'b1; // R18
          st_nxt.rd_data = common_word;
        end
        default: begin
          st_nxt.rd_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= MSR_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // alert pad only ever pulled low, released otherwise
  assign o_alertb_o  = 1'b0;
  assign o_alertb_oe = st_r.alert;
  assign o_rd_valid  = st_r.rd_valid;
  assign o_rd_data   = st_r.rd_data;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence seq_pad_read;
    i_cmd_valid && !refuse && i_cmd_code == MSR_CMD_PAD_READBACK;
  endsequence

  sequence seq_common_read;
    i_cmd_valid && i_cmd_code == MSR_CMD_COMMON_STAT;
  endsequence

  sequence seq_status_read;
    i_cmd_valid && !refuse && i_cmd_code == MSR_CMD_VENDOR_STAT;
  endsequence

  // per-channel flag behaviour
  for (genvar c = 0; c < N; c++) begin : g_chk
    localparam int B = c * MSR_K_PER_CH;
    discharge_sticky_a: assert property ( // R1
      i_discharge_fault[c] && i_on_attempt[c] |=> bank_if.q[B+MSR_K_DISCHARGE] && o_alertb_oe)
      else $error("discharge flag or alert missing");
    line_one_a: assert property ( // R2
      i_on_attempt[c] && line_one_low |=> bank_if.q[B+MSR_K_FAULT_ONE])
      else $error("fault line one flag not set");
    line_zero_a: assert property ( // R3
      i_shut_fault_zero[c] |=> bank_if.q[B+MSR_K_FAULT_ZERO] ##0 o_alertb_oe)
      else $error("fault line zero flag not set");
    line_hold_a: assert property ( // R4
      bank_if.q[B+MSR_K_FAULT_ZERO] && !i_clear_faults && !i_user_on[c] && !ctl_toggle[c]
      |=> bank_if.q[B+MSR_K_FAULT_ZERO])
      else $error("fault line flag dropped early");
    toggle_clear_a: assert property ( // R4
      ctl_toggle[c] && !bank_if.set[B+MSR_K_FAULT_ONE] |=> !bank_if.q[B+MSR_K_FAULT_ONE])
      else $error("control toggle did not clear");
    track_cause_a: assert property ( // R5
      i_track_en[c] && i_cause_fault_one[c] |=> bank_if.q[B+MSR_K_FAULT_ONE])
      else $error("tracking cause flag not set");
    sat_sticky_a: assert property ( // R7
      i_servo_done[c] && i_dac_at_limit[c] && !o_alertb_oe && !alert_event
      |=> bank_if.q[B+MSR_K_DAC_SAT] && !o_alertb_oe)
      else $error("saturation flag wrong");
    turn_on_clear_a: assert property ( // R21
      i_user_on[c] && !bank_if.set[B+MSR_K_DISCHARGE] |=> !bank_if.q[B+MSR_K_DISCHARGE])
      else $error("turn-on did not clear discharge flag");
  end

  live_bits_a: assert property ( // R6
    seq_status_read |=> o_rd_valid && o_rd_data[MSR_ST_SERVO_HIT] == $past(i_servo_reached[sel])
    && o_rd_data[MSR_ST_DAC_ON] == $past(i_dac_connected[sel]))
    else $error("live servo bits wrong");
  aux_bit_a: assert property ( // R8
    seq_status_read |=> o_rd_data[MSR_ST_AUX_OFF] == $past(i_aux_released))
    else $error("auxiliary release bit wrong");
  watchdog_set_a: assert property ( // R9
    i_watchdog_fault |=> bank_if.q[MSR_STICKY_WDG] && o_alertb_oe && o_chan_off_event == '0)
    else $error("watchdog flag or alert wrong");
  pad_drive_a: assert property ( // R11
    seq_pad_read |=> o_rd_data[MSR_PD_PWRGD_DRV] == !$past(i_pwrgd_drive_low)
    && o_rd_data[MSR_PD_ALERT_DRV] == !$past(st_r.alert))
    else $error("own drive bits wrong");
  pad_fault_a: assert property ( // R13
    seq_pad_read |=> o_rd_data[MSR_PD_FAULT_DRV_HI] == !$past(i_fault_zero_drive_low)
    && o_rd_data[MSR_PD_RSVD_HI -: 2] == 2'h0
    && o_rd_data[MSR_PD_FAULT_HI] == $past(pad_sy[MSR_SY_FAULT0]))
    else $error("fault pad bits wrong");
  asel_code_a: assert property ( // R14
    seq_pad_read |=> o_rd_data[MSR_PD_ADDRESS_SELECT_ONE_LSB +: 2] != 2'h1
    && o_rd_data[MSR_PD_ADDRESS_SELECT_ZERO_LSB +: 2] != 2'h1)
    else $error("reserved address code shown");
  ctrl_pad_a: assert property ( // R16
    seq_pad_read |=> o_rd_data[MSR_PD_CTRL3] == $past(pad_sy[MSR_SY_CTRL_LSB + 3])
    && o_rd_data[MSR_PD_CTRL1] == $past(pad_sy[MSR_SY_CTRL_LSB + 1]))
    else $error("control pad bits wrong");
  common_busy_a: assert property ( // R18
    seq_common_read |-> !o_cmd_nack ##1 o_rd_valid && o_rd_data[MSR_CM_AVAIL] == !$past(i_busy))
    else $error("common status not served");
  busy_refuse_a: assert property ( // R19
    i_cmd_valid && i_busy && i_cmd_code == MSR_CMD_PAD_READBACK
    |-> o_cmd_nack && o_busy_flag_set ##1 !o_rd_valid)
    else $error("busy device took a command");
  nack_quiet_a: assert property ( // R20
    o_cmd_nack && !o_alertb_oe && !alert_event |=> !o_alertb_oe)
    else $error("refusal pulled alert");
  reset_clear_a: assert property (@(posedge i_sys_clk) disable iff (1'b0) // R24
    !i_resetn ##1 !i_resetn |-> bank_if.q == '0 && !o_alertb_oe)
    else $error("flags not clear in reset");
endmodule

// ### design/msr_pkg.sv
// constants and state types shared by the manager status block
package msr_pkg;
  // channel count and command codes
  localparam int          MSR_CHANNELS         = 4;
  localparam logic [7:0]  MSR_CMD_VENDOR_STAT  = 8'hD0;
  localparam logic [7:0]  MSR_CMD_PAD_READBACK = 8'hD1;
  localparam logic [7:0]  MSR_CMD_COMMON_STAT  = 8'hD2;

  // bit positions inside vendor_channel_status
  localparam int MSR_ST_DISCHARGE = 7;
  localparam int MSR_ST_FAULT_ONE = 6;
  localparam int MSR_ST_FAULT_ZERO = 5;
  localparam int MSR_ST_SERVO_HIT = 4;
  localparam int MSR_ST_DAC_ON = 3;
  localparam int MSR_ST_DAC_SAT = 2;
  localparam int MSR_ST_AUX_OFF = 1;
  localparam int MSR_ST_WATCHDOG = 0;

  // bit positions inside pad_level_readback
  localparam int MSR_PD_PWRGD_DRV = 15;
  localparam int MSR_PD_ALERT_DRV = 14;
  localparam int MSR_PD_FAULT_DRV_HI = 13;
  localparam int MSR_PD_FAULT_DRV_LO = 12;
  localparam int MSR_PD_RSVD_HI = 11;
  localparam int MSR_PD_ADDRESS_SELECT_ONE_LSB = 8;
  localparam int MSR_PD_ADDRESS_SELECT_ZERO_LSB = 6;
  localparam int MSR_PD_CTRL1 = 5;
  localparam int MSR_PD_CTRL0 = 4;
  localparam int MSR_PD_FAULT_HI = 3;
  localparam int MSR_PD_FAULT_LO = 2;
  localparam int MSR_PD_CTRL2 = 1;
  localparam int MSR_PD_CTRL3 = 0;
  localparam logic [1:0] MSR_PD_RSVD_VAL = 2'h0;

  // address-select pad codes
  localparam logic [1:0] MSR_ASEL_HIGH  = 2'h3;
  localparam logic [1:0] MSR_ASEL_FLOAT = 2'h2;
  localparam logic [1:0] MSR_ASEL_LOW   = 2'h0;

  // common status layout
  localparam int         MSR_CM_ALERT = 7;
  localparam int         MSR_CM_AVAIL = 6;
  localparam logic [3:0] MSR_CM_RSVD_VAL = 4'hF;

  // sticky bank layout: four slots per channel, watchdog last
  localparam int MSR_K_DISCHARGE = 0;
  localparam int MSR_K_FAULT_ONE = 1;
  localparam int MSR_K_FAULT_ZERO = 2;
  localparam int MSR_K_DAC_SAT = 3;
  localparam int MSR_K_PER_CH = 4;
  localparam int MSR_STICKY_W = 17;
  localparam int MSR_STICKY_WDG = 16;
  localparam logic [16:0] MSR_STICKY_RST = 17'h00000;

  // synchronised pad vector layout
  localparam int MSR_SY_W = 12;
  localparam int MSR_SY_CTRL_LSB = 0;
  localparam int MSR_SY_FAULT1 = 4;
  localparam int MSR_SY_FAULT0 = 5;
  localparam int MSR_SY_ADDRESS_SELECT_ZERO_FLT = 6;
  localparam int MSR_SY_ADDRESS_SELECT_ZERO_HI = 7;
  localparam int MSR_SY_ADDRESS_SELECT_ONE_FLT = 8;
  localparam int MSR_SY_ADDRESS_SELECT_ONE_HI = 9;
  localparam int MSR_SY_WP = 10;
  localparam int MSR_SY_SHARE_LOW = 11;

  typedef struct packed {
    logic [3:0]  ctl_prev;
    logic        ctl_prev_ok;
    logic        alert;
    logic        rd_valid;
    logic [15:0] rd_data;
  } msr_state_s;

  localparam msr_state_s MSR_STATE_RST = '{4'h0, 1'b0, 1'b0, 1'b0, 16'h0000};
endpackage

// ### design/msr_sticky_if.sv
// set, clear and held flags of the sticky flag bank
interface msr_sticky_if #(parameter int W = 17);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] q;
  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface

// ### design/msr_sync.sv
// two-stage synchroniser for pad levels
module msr_sync #(
  parameter int W = 12
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } msr_sync_s;

  msr_sync_s st_r;
  msr_sync_s st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.s2;
endmodule

// ### design/msr_sticky.sv
// bank of sticky flags where a set beats a same-cycle clear
module msr_sticky
  import msr_pkg::*;
#(
  parameter int W = 17
) (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  msr_sticky_if.owner bank
);
  typedef struct packed {
    logic [W-1:0] flags;
  } msr_bank_s;

  msr_bank_s st_r;
  msr_bank_s st_nxt;

  // set wins so an event landing on the clear cycle is kept
  always_comb begin
    st_nxt.flags = (st_r.flags & ~bank.clr) | bank.set;
  end

  // flags start clear before any fault is seen
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r.flags <= MSR_STICKY_RST[W-1:0]; // R24
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bank.q = st_r.flags;
endmodule

// ### bench/msr_pad_model.sv
// pad model for the address-select pads seen by the manager
module msr_pad_model (
  input  wire logic       i_sys_clk,
  input  wire logic [1:0] i_address_select_zero,
  input  wire logic [1:0] i_address_select_one,
  output logic            o_a0_hi,
  output logic            o_a0_flt,
  output logic            o_a1_hi,
  output logic            o_a1_flt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tgl_r = 1'h0;

  // a floating pad gives no steady level, so its high sense flips every cycle
  always @(posedge i_sys_clk) begin
    tgl_r <= #2 ~tgl_r;
  end

  // float detect wins; otherwise the level sense is the pad itself
  assign o_a0_flt = (i_address_select_zero == 2'h2);
  assign o_a0_hi  = o_a0_flt ? tgl_r : i_address_select_zero[0];
  assign o_a1_flt = (i_address_select_one == 2'h2);
  assign o_a1_hi  = o_a1_flt ? tgl_r : i_address_select_one[0];
endmodule

// ### bench/tb_top.sv
// self-checking bench for the manager status block
module tb_top
  import msr_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rstn = 1'h0, vld = 1'h0, busy = 1'h0, clrf = 1'h0, aux = 1'h0;
  logic wdg = 1'h0, pgl = 1'h0, f0l = 1'h0, f1l = 1'h0, fl0 = 1'h1, fl1 = 1'h1;
  logic wp = 1'h0, shl = 1'h0, al_e = 1'h0, ew = 1'h0;
  logic [7:0] code = '0;
  logic [1:0] page = '0, a0 = '0, a1 = '0;
  logic [3:0] uon = '0, onat = '0, dis = '0, sf1 = '0, sf0 = '0, srv = '0, dac = '0;
  logic [3:0] sdn = '0, lim = '0, ctl = '0, e7 = '0, e6 = '0, e5 = '0, e2 = '0;
  logic [3:0] trk = '0, cf1 = '0, cf0 = '0;
  logic nack, bfs, rv, aoo, aoe, a0h, a0f, a1h, a1f;
  logic [15:0] rd;
  logic [3:0] off;
  logic [1:0] ac [3] = '{MSR_ASEL_HIGH, MSR_ASEL_FLOAT, MSR_ASEL_LOW};
  logic [15:0] exp_q [$];
  int fails = 0;
  int checks_done = 0;

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  msr_pad_model pm (.i_sys_clk(clk), .i_address_select_zero(a0), .i_address_select_one(a1), .o_a0_hi(a0h),
    .o_a0_flt(a0f), .o_a1_hi(a1h), .o_a1_flt(a1f));
  msr_top dut (.i_sys_clk(clk), .i_resetn(rstn), .i_cmd_valid(vld), .i_cmd_code(code),
    .i_cmd_page(page), .i_busy(busy), .o_cmd_nack(nack), .o_busy_flag_set(bfs),
    .o_rd_valid(rv), .o_rd_data(rd), .i_clear_faults(clrf), .i_user_on(uon),
    .i_on_attempt(onat), .i_discharge_fault(dis), .i_shut_fault_one(sf1),
    .i_shut_fault_zero(sf0), .i_track_en(trk), .i_cause_fault_one(cf1),
    .i_cause_fault_zero(cf0), .i_servo_reached(srv), .i_dac_connected(dac),
    .i_servo_done(sdn), .i_dac_at_limit(lim), .i_aux_released(aux),
    .i_watchdog_fault(wdg), .i_pwrgd_drive_low(pgl), .i_fault_zero_drive_low(f0l),
    .i_fault_one_drive_low(f1l), .i_pad_channel_control(ctl),
    .i_pad_shared_fault_line_zero(fl0), .i_pad_shared_fault_line_one(fl1),
    .i_pad_address_select_zero_hi(a0h), .i_pad_address_select_zero_float(a0f),
    .i_pad_address_select_one_hi(a1h), .i_pad_address_select_one_float(a1f),
    .i_pad_write_protect(wp), .i_pad_share_clk_low(shl),
    .i_alertb_i(aoe ? aoo : 1'h1), .o_alertb_o(aoo), .o_alertb_oe(aoe),
    .o_chan_off_event(off));

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string what);
    cmp_word({15'h0, got}, {15'h0, exp}, what);
  endtask

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // expected words worked out from the bench's own copy of the flags
  function automatic logic [15:0] vs(input logic [1:0] p);
    return {8'h00, e7[p], e6[p], e5[p], srv[p], dac[p], e2[p], aux, ew};
  endfunction
  function automatic logic [15:0] pads();
    return {~pgl, ~al_e, ~f0l, ~f1l, 2'h0, a1, a0, ctl[1], ctl[0], fl0, fl1, ctl[2], ctl[3]};
  endfunction
  function automatic logic [15:0] cm();
    return {8'h00, ~al_e, ~busy, 4'hF, shl, wp};
  endfunction

  // one command strobe; refusal is checked in its own cycle, answers go to the queue
  task automatic cmd(input logic [7:0] c, input logic [1:0] p, input logic [15:0] e);
    logic nk;
    nk = busy && (c != MSR_CMD_COMMON_STAT);
    vld = 1'h1;
    code = c;
    page = p;
    if (!nk) exp_q.push_back(e);
    #1;
    cmp_bit(nack, nk, "nack");
    cmp_bit(bfs, nk, "busy flag");
    tick(1);
    vld = 1'h0;
    tick(1);
  endtask

  // scoreboard: each read answer takes the oldest queued expectation
  always @(posedge clk) begin
    if (rv === 1'h1) begin
      if (exp_q.size() == 0) cmp_bit(1'h1, 1'h0, "unexpected read");
      else cmp_word(rd, exp_q.pop_front(), "read data");
    end
  end

  // hang guard
  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'hE4B612C1));
    tick(20);
    rstn = 1'h1;
    tick(3);
    for (int p = 0; p < 4; p++) begin
      {srv, dac, aux} = 9'($urandom);
      cmd(MSR_CMD_VENDOR_STAT, 2'(p), vs(2'(p)));
    end
    cmd(MSR_CMD_COMMON_STAT, 2'h0, cm());
    // every address-select code pair with random other pads
    for (int i = 0; i < 9; i++) begin
      {pgl, f0l, f1l, ctl, fl0, fl1, wp, shl} = 11'($urandom);
      a0 = ac[i % 3];
      a1 = ac[i / 3];
      tick(3);
      cmd(MSR_CMD_PAD_READBACK, 2'h0, pads());
      cmd(MSR_CMD_COMMON_STAT, 2'h0, cm());
    end
    {fl0, fl1} = 2'h3;
    tick(3);
    // discharge only counts on a channel that is turning on
    dis = 4'hC;
    onat = 4'h4;
    #1;
    cmp_word({12'h0, off}, 16'h0004, "off event");
    tick(1);
    dis = 4'h0;
    onat = 4'h0;
    e7[2] = 1'h1;
    al_e = 1'h1;
    cmp_bit(aoe, 1'h1, "alert drive");
    cmp_bit(aoo, 1'h0, "alert level");
    cmd(MSR_CMD_VENDOR_STAT, 2'h2, vs(2'h2));
    cmd(MSR_CMD_VENDOR_STAT, 2'h3, vs(2'h3));
    cmd(MSR_CMD_PAD_READBACK, 2'h0, pads());
    uon = 4'h4;
    tick(1);
    uon = 4'h0;
    e7[2] = 1'h0;
    cmd(MSR_CMD_VENDOR_STAT, 2'h2, vs(2'h2));
    // shutdowns on the shared lines, then a control toggle on channel one
    sf1 = 4'h2;
    sf0 = 4'h1;
    tick(1);
    {sf1, sf0} = 8'h00;
    e6[1] = 1'h1;
    e5[0] = 1'h1;
    cmd(MSR_CMD_VENDOR_STAT, 2'h1, vs(2'h1));
    cmd(MSR_CMD_VENDOR_STAT, 2'h0, vs(2'h0));
    ctl[1] = ~ctl[1];
    tick(4);
    e6[1] = 1'h0;
    cmd(MSR_CMD_VENDOR_STAT, 2'h1, vs(2'h1));
    cmd(MSR_CMD_VENDOR_STAT, 2'h0, vs(2'h0));
    {fl0, fl1} = 2'h0;
    onat = 4'h8;
    tick(4);
    {e6[3], e5[3]} = 2'h3;
    cmd(MSR_CMD_VENDOR_STAT, 2'h3, vs(2'h3));
    onat = 4'h0;
    {fl0, fl1} = 2'h3;
    clrf = 1'h1;
    tick(1);
    clrf = 1'h0;
    {e7, e6, e5, e2, al_e} = 17'h0;
    cmp_bit(aoe, 1'h0, "alert released");
    cmd(MSR_CMD_VENDOR_STAT, 2'h3, vs(2'h3));
    // servo ending at the converter limit, without alert
    sdn = 4'h3;
    lim = 4'h1;
    tick(1);
    sdn = 4'h0;
    e2[0] = 1'h1;
    cmd(MSR_CMD_VENDOR_STAT, 2'h0, vs(2'h0));
    cmd(MSR_CMD_VENDOR_STAT, 2'h1, vs(2'h1));
    cmp_bit(aoe, 1'h0, "no alert");
    busy = 1'h1;
    cmd(MSR_CMD_VENDOR_STAT, 2'h0, 16'h0000);
    cmd(MSR_CMD_PAD_READBACK, 2'h0, 16'h0000);
    cmd(MSR_CMD_COMMON_STAT, 2'h0, cm());
    cmp_bit(aoe, 1'h0, "no alert");
    busy = 1'h0;
    // watchdog: global, alerting, never a turn-off, cleared only by clear
    wdg = 1'h1;
    #1;
    cmp_word({12'h0, off}, 16'h0000, "off event");
    tick(1);
    wdg = 1'h0;
    {ew, al_e} = 2'h3;
    cmp_bit(aoe, 1'h1, "alert drive");
    uon = 4'hF;
    tick(1);
    uon = 4'h0;
    e2[0] = 1'h0;
    cmd(MSR_CMD_VENDOR_STAT, 2'h1, vs(2'h1));
    cmd(MSR_CMD_COMMON_STAT, 2'h0, cm());
    // tracking flags the causing channel only where tracking is on
    trk = 4'h2;
    {cf1, cf0} = 8'h23;
    tick(1);
    {trk, cf1, cf0} = 12'h0;
    {e6[1], e5[1]} = 2'h3;
    cmd(MSR_CMD_VENDOR_STAT, 2'h1, vs(2'h1));
    cmd(MSR_CMD_VENDOR_STAT, 2'h0, vs(2'h0));
    clrf = 1'h1;
    tick(1);
    clrf = 1'h0;
    {e6, e5, ew, al_e} = 10'h0;
    cmd(MSR_CMD_VENDOR_STAT, 2'h1, vs(2'h1));
    cmd(MSR_CMD_PAD_READBACK, 2'h0, pads());
    // reset in mid-run must drop a freshly set flag and the alert latch
    wdg = 1'h1;
    tick(1);
    {wdg, rstn} = 2'h0;
    tick(2);
    rstn = 1'h1;
    tick(3);
    cmp_bit(aoe, 1'h0, "alert after reset");
    cmd(MSR_CMD_VENDOR_STAT, 2'h1, vs(2'h1));
    tick(2);
    cmp_bit(exp_q.size() == 0, 1'h1, "queue drained");
    wrap_up();
  end
endmodule
